// *** vicr_consts.vh ***
// Overview of operation
// - Bits 31 to 29 report the virtual priority bit count minus one, with at least five bits implemented.
// - Bits 28 to 26 report the virtual preemption bit count minus one, with at least five bits implemented.
// - The reported preemption count never exceeds the reported priority count.
// - Bits 25 to 23 give the identifier width, 000 for 16 bits and 001 for 24 bits, and no other code is reported.
// - Bit 22 is one only when the virtual interface can raise system error interrupts.
// - Bit 21 is one when nonzero top-level affinity is accepted in software interrupt generation.
// - Bit 20 is zero when direct injection is supported and one when it is not.
// - Bit 19 is one when separate trapping of virtual deactivate writes is supported.
// - Bits 4 to 0 report the list register count minus one, sixteen at most.
// - With no hypervisor level, reads from the highest level return zero except bit 20, which reads one.
// - The register is read with coprocessor 1111, opcode1 100, CRn 1100, CRm 1011 and opcode2 001.
// - A hypervisor-level access with its system register enable low is undefined, otherwise it returns the value.
// - A kernel-level access traps to the hypervisor with code 03 when a hypervisor level exists and the trap bit is set, else it is undefined.
`ifndef VICR_CONSTS_VH
`define VICR_CONSTS_VH

`define VICR_PRI_HI      31
`define VICR_PRI_LO      29
`define VICR_PRE_HI      28
`define VICR_PRE_LO      26
`define VICR_ID_HI       25
`define VICR_ID_LO       23
`define VICR_SEI_BIT     22
`define VICR_A3_BIT      21
`define VICR_NODI_BIT    20
`define VICR_SDT_BIT     19
`define VICR_LR_HI       4
`define VICR_LR_LO       0

`define VICR_PRI_MIN     3'h4
`define VICR_ID_16       3'h0
`define VICR_ID_24       3'h1
`define VICR_LR_MAX      5'h0F

`define VICR_COPROC      4'hF
`define VICR_OPC1        3'h4
`define VICR_CRN         4'hC
`define VICR_CRM         4'hB
`define VICR_OPC2        3'h1

`define VICR_EL0         2'h0
`define VICR_EL1         2'h1
`define VICR_EL2         2'h2
`define VICR_EL3         2'h3

`define VICR_TRAP_EC     6'h03
`define VICR_ZERO32      32'h00000000

`endif

// *** vicr_value.v ***
`include "vicr_consts.vh"

module vicr_value #(
  parameter [2:0] PRI_M1   = 3'h4,
  parameter [2:0] PRE_M1   = 3'h4,
  parameter [2:0] ID_CODE  = 3'h0,
  parameter       SEI_SUP  = 1'b0,
  parameter       A3_SUP   = 1'b0,
  parameter       DI_SUP   = 1'b0,
  parameter       SDT_SUP  = 1'b0,
  parameter [4:0] LR_M1    = 5'h03
) (
  output wire [31:0] value
);

  // Clamp configuration so an illegal setting can never be reported.
  wire [2:0] pri_w;
  wire [2:0] pre_w;
  wire [2:0] id_w;
  wire [4:0] lr_w;

  assign pri_w = (PRI_M1 < `VICR_PRI_MIN) ? `VICR_PRI_MIN : PRI_M1;
  assign pre_w = (PRE_M1 < `VICR_PRI_MIN) ? `VICR_PRI_MIN :
                 ((PRE_M1 > pri_w) ? pri_w : PRE_M1);
  assign id_w  = (ID_CODE == `VICR_ID_24) ? `VICR_ID_24 : `VICR_ID_16;
  assign lr_w  = (LR_M1 > `VICR_LR_MAX) ? `VICR_LR_MAX : LR_M1;

  assign value = {pri_w, pre_w, id_w,
                  SEI_SUP[0],
                  A3_SUP[0],
                  ~DI_SUP[0],
                  SDT_SUP[0],
                  14'h0000, lr_w};

endmodule

// *** vicr_capability.v ***
`include "vicr_consts.vh"

module vicr_capability #(
  parameter [2:0] PRI_M1   = 3'h4,
  parameter [2:0] PRE_M1   = 3'h4,
  parameter [2:0] ID_CODE  = 3'h0,
  parameter       SEI_SUP  = 1'b0,
  parameter       A3_SUP   = 1'b0,
  parameter       DI_SUP   = 1'b0,
  parameter       SDT_SUP  = 1'b0,
  parameter [4:0] LR_M1    = 5'h03,
  parameter       HYP_IMPL = 1'b1
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  input  wire        req_valid,
  input  wire        req_read,
  input  wire [3:0]  req_coproc,
  input  wire [2:0]  req_opc1,
  input  wire [3:0]  req_crn,
  input  wire [3:0]  req_crm,
  input  wire [2:0]  req_opc2,
  input  wire [1:0]  req_el,
  input  wire        hyp_sysreg_enable,
  input  wire        monitor_sysreg_enable,
  input  wire        hyp_coproc_trap_bit,
  output reg         rsp_valid,
  output reg         rsp_hit,
  output reg  [31:0] rsp_data,
  output reg         rsp_undef,
  output reg         rsp_trap,
  output reg  [5:0]  rsp_trap_code
);

  // ------------------------------------------------------------
  // Capability value
  // ------------------------------------------------------------
  wire [31:0] cap_value;
  wire [31:0] no_hyp_value;
  wire [31:0] read_value;

  vicr_value #(
    .PRI_M1  (PRI_M1),
    .PRE_M1  (PRE_M1),
    .ID_CODE (ID_CODE),
    .SEI_SUP (SEI_SUP),
    .A3_SUP  (A3_SUP),
    .DI_SUP  (DI_SUP),
    .SDT_SUP (SDT_SUP),
    .LR_M1   (LR_M1)
  ) u_value (
    .value (cap_value)
  );

  // Without a hypervisor level only the direct-injection-unsupported bit is set.
  assign no_hyp_value = `VICR_ZERO32 | (32'h00000001 << `VICR_NODI_BIT);
  assign read_value   = HYP_IMPL ? cap_value : no_hyp_value;

  // ------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------
  wire enc_hit;
  wire is_el1;
  wire is_el2;
  wire is_el3;
  wire rd_ok;
  wire trap_nxt;
  wire undef_nxt;

  // Writes match no encoding: the register has no write path.
  assign enc_hit = req_read && (req_coproc == `VICR_COPROC) && (req_opc1 == `VICR_OPC1) &&
                   (req_crn == `VICR_CRN) && (req_crm == `VICR_CRM) &&
                   (req_opc2 == `VICR_OPC2);
  assign is_el1  = (req_el == `VICR_EL1);
  assign is_el2  = (req_el == `VICR_EL2) && HYP_IMPL;
  assign is_el3  = (req_el == `VICR_EL3);

  assign rd_ok     = (is_el2 && hyp_sysreg_enable) || (is_el3 && monitor_sysreg_enable);
  assign trap_nxt  = is_el1 && HYP_IMPL && hyp_coproc_trap_bit;
  assign undef_nxt = !rd_ok && !trap_nxt;

  // ------------------------------------------------------------
  // Response registers
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      rsp_valid     <= 1'b0;
      rsp_hit       <= 1'b0;
      rsp_data      <= `VICR_ZERO32;
      rsp_undef     <= 1'b0;
      rsp_trap      <= 1'b0;
      rsp_trap_code <= 6'h00;
    end else if (ce) begin
      rsp_valid <= req_valid;
      rsp_hit   <= req_valid && enc_hit;
      if (req_valid && enc_hit) begin
        rsp_data      <= rd_ok ? read_value : `VICR_ZERO32;
        rsp_undef     <= undef_nxt;
        rsp_trap      <= trap_nxt;
        rsp_trap_code <= trap_nxt ? `VICR_TRAP_EC : 6'h00;
      end else begin
        rsp_data      <= `VICR_ZERO32;
        rsp_undef     <= 1'b0;
        rsp_trap      <= 1'b0;
        rsp_trap_code <= 6'h00;
      end
    end
  end

endmodule

// *** vicr_chk_sva.sv ***
module vicr_chk #(
  parameter bit HYP_IMPL = 1'b1
) (
  input logic        clk, rst, ce, req_valid, req_read,
  input logic [3:0]  req_coproc, req_crn, req_crm,
  input logic [2:0]  req_opc1, req_opc2,
  input logic [1:0]  req_el,
  input logic        hyp_sysreg_enable, monitor_sysreg_enable, hyp_coproc_trap_bit,
  input logic        rsp_valid, rsp_hit, rsp_undef, rsp_trap,
  input logic [5:0]  rsp_trap_code,
  input logic [31:0] rsp_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire m = req_read && {req_coproc, req_opc1, req_crn, req_crm, req_opc2} == {4'hF, 3'h4, 4'hC, 4'hB, 3'h1};
  wire t = ce && req_valid && m;
  chk_answer_next: assert property (ce && req_valid |=> rsp_valid) else $error("no answer");
  chk_miss_empty: assert property (ce && req_valid && !m |=> !rsp_hit && rsp_data == 32'h0)
    else $error("miss answered");
  chk_hit_seen: assert property (t |=> rsp_hit) else $error("hit lost");
  chk_hyp_gate: assert property (t && req_el == 2'h2 && !hyp_sysreg_enable |=> rsp_undef && rsp_data == 32'h0)
    else $error("hyp gate");
  chk_hyp_read: assert property (HYP_IMPL && t && req_el == 2'h2 && hyp_sysreg_enable
    |=> !rsp_undef && rsp_data != 32'h0) else $error("hyp read");
  chk_kernel_trap: assert property (HYP_IMPL && t && req_el == 2'h1 && hyp_coproc_trap_bit
    |=> rsp_trap && rsp_trap_code == 6'h03) else $error("no trap");
  chk_nohyp_value: assert property (!HYP_IMPL && t && req_el == 2'h3 && monitor_sysreg_enable
    |=> rsp_data == 32'h00100000) else $error("no hyp value");
  chk_nohyp_lower: assert property (!HYP_IMPL && t && req_el != 2'h3
    |=> rsp_undef && !rsp_trap && rsp_data == 32'h0) else $error("no hyp lower level");
  chk_user_undef: assert property (t && req_el == 2'h0 |=> rsp_undef && !rsp_trap) else $error("user read");
  chk_pre_le_pri: assert property (rsp_data[28:26] <= rsp_data[31:29]) else $error("pre gt pri");
  chk_id_code: assert property (rsp_data[25:24] == 2'h0) else $error("id code");
  chk_list_max: assert property (rsp_data[18:4] == 15'h0) else $error("list count");
  chk_freeze: assert property (!ce |=> $stable(rsp_data) && $stable(rsp_valid)) else $error("not frozen");
  cover property (t && req_el == 2'h2 && hyp_sysreg_enable);
  cover property (t && req_el == 2'h1 && hyp_coproc_trap_bit);
  cover property (!ce && rsp_valid);
  cover property (!HYP_IMPL && t && req_el == 2'h3 && monitor_sysreg_enable);
endmodule

bind vicr_capability vicr_chk #(.HYP_IMPL(HYP_IMPL)) i_chk (.*);

// *** tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [17:0] M = {4'hF, 3'h4, 4'hC, 4'hB, 3'h1};
  localparam logic [31:0] V = {3'h5, 3'h5, 3'h1, 4'hD, 14'h0, 5'h0F};
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, req_valid = 1'b0, req_read = 1'b0;
  logic [3:0]  req_coproc = 4'h0, req_crn = 4'h0, req_crm = 4'h0;
  logic [2:0]  req_opc1 = 3'h0, req_opc2 = 3'h0;
  logic [1:0]  req_el = 2'h0;
  logic        hyp_sysreg_enable = 1'b0, monitor_sysreg_enable = 1'b0, hyp_coproc_trap_bit = 1'b0;
  logic        rsp_valid, rsp_hit, rsp_undef, rsp_trap;
  logic [5:0]  rsp_trap_code;
  logic [31:0] rsp_data;
  logic        nh_valid, nh_hit, nh_undef, nh_trap;
  logic [5:0]  nh_trap_code;
  logic [31:0] nh_data;
  int          fail_count = 0, cmp_count = 0, cyc = 0;
  always #2.5 clk = ~clk;
  // Preemption is configured above priority on purpose, so the clamp must pull it down.
  vicr_capability #(.PRI_M1(3'h5), .PRE_M1(3'h7), .ID_CODE(3'h1), .SEI_SUP(1'b1), .A3_SUP(1'b1),
                    .DI_SUP(1'b1), .SDT_SUP(1'b1), .LR_M1(5'h0F)) i_dut (.*);
  // Second copy built without a hypervisor level.
  vicr_capability #(.HYP_IMPL(1'b0)) i_dut_nohyp (.*, .rsp_valid(nh_valid), .rsp_hit(nh_hit), .rsp_undef(nh_undef),
                                                  .rsp_trap(nh_trap), .rsp_trap_code(nh_trap_code), .rsp_data(nh_data));
  task automatic chk(input logic [41:0] s, input logic [41:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Flags f are hyp enable, monitor enable, trap bit.
  task automatic rq(input logic [1:0] e, input logic [2:0] f, input logic [17:0] enc, input logic rd);
    logic        h, ok, tr, ok2;
    logic [41:0] x, x2;
    h = rd && enc == M;
    ok = (e == 2'h2 && f[2]) || (e == 2'h3 && f[1]);
    tr = e == 2'h1 && f[0];
    ok2 = e == 2'h3 && f[1];
    x = {1'b1, h, h && !ok && !tr, h && tr, h && tr ? 6'h03 : 6'h00, h && ok ? V : 32'h0};
    x2 = {1'b1, h, h && !ok2, 1'b0, 6'h00, h && ok2 ? 32'h00100000 : 32'h0};
    @(posedge clk);
    {req_el, hyp_sysreg_enable, monitor_sysreg_enable, hyp_coproc_trap_bit} <= {e, f};
    {req_coproc, req_opc1, req_crn, req_crm, req_opc2} <= enc;
    req_read <= rd;
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    #1 chk({rsp_valid, rsp_hit, rsp_undef, rsp_trap, rsp_trap_code, rsp_data}, x);
    chk({nh_valid, nh_hit, nh_undef, nh_trap, nh_trap_code, nh_data}, x2);
  endtask
  task automatic t_access;
    for (int i = 0; i < 32; i++) rq(i[4:3], i[2:0], M, 1'b1);
  endtask
  task automatic t_decode;
    for (int k = 0; k < 18; k++) rq(2'h3, 3'h7, M ^ (18'h1 << k), 1'b1);
    rq(2'h3, 3'h7, M, 1'b0);
  endtask
  task automatic t_freeze;
    rq(2'h3, 3'h7, M, 1'b1);
    @(posedge clk);
    req_valid <= 1'b1;
    @(posedge clk);
    ce <= 1'b0;
    req_valid <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({9'h0, rsp_valid, rsp_data}, {9'h0, 1'b1, V});
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    #1 chk({9'h0, rsp_valid, rsp_data}, {9'h0, 1'b0, 32'h0});
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      fail_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_access();
    t_decode();
    t_freeze();
    give_verdict();
  end
endmodule
